// ===== fault_status_params.svh
/*
 Register offsets, field positions, reset values
 and thresholds of the fault status byte block.
 Assumes inclusion by bare name from design files.
*/
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// Byte offsets on the register bus
`define OFS_CTRL        6'h00
`define OFS_SPEED_LIM   6'h04
`define OFS_STATUS      6'h08
`define OFS_IRQ_STAT    6'h0C
`define OFS_IRQ_MASK    6'h10

// Control register fields
`define CTRL_AUTO_ACK   0
`define CTRL_REPORT_EN  1
`define CTRL_EXT_LO     2
`define CTRL_EXT_HI     3
`define CTRL_VAL_LO     4
`define CTRL_VAL_HI     5
`define CTRL_OUT_LO     6
`define CTRL_OUT_HI     8

// Reset values
`define CTRL_RESET      9'h000
`define SPEED_RESET     16'h0000
`define MASK_RESET      8'h00

// Status byte bit positions
`define BIT_INTENS      0
`define BIT_TEMP        1
`define BIT_HW          2
`define BIT_LASER_OFF   3
`define BIT_WARN_INT    4
`define BIT_WARN_SPD    5
`define BIT_WARN_PLS    6

// Intensity limits in percent, temperature band in degC
`define INTENS_MIN_PCT  7'h08
`define INTENS_WARN_PCT 7'h0C
`define TEMP_LOW_C      8'sh00
`define TEMP_HIGH_C     8'sh32

`endif

// ===== fault_status_pkg.sv
/*
 Types of the fault status byte block.
 Assumes fault_status_params.svh holds the numbers.
*/
package fault_status_pkg;

  // Use of the external switching input
  typedef enum logic [1:0] {
    EXT_OFF, EXT_PRESET, EXT_LASER, EXT_ACK
  } ext_func_e;

  // Position shown while no measurement exists
  typedef enum logic [1:0] {
    VAL_ZERO, VAL_ONES, VAL_LAST, VAL_RSVD
  } err_val_e;

  // Register bus answer phase
  typedef enum logic {
    BUS_WAIT, BUS_DONE
  } bus_state_e;

endpackage : fault_status_pkg

// ===== fault_latch.sv
/*
 Latched error bits with manual or automatic clear.
 Assumes a one-cycle acknowledge pulse, one clock.
*/
`timescale 1ns/1ps
module fault_latch (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       autoAck,
  input  wire logic       ackPulse,
  // Fault causes and latched codes
  input  wire logic [2:0] errCond,
  output logic      [2:0] errLatch
);

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      // Clear source: cause gone, or acknowledge
      wire clrBit = autoAck ? ~errCond[i] : ackPulse;
      // Set wins over clear, so no event is lost
      wire bitNext = errCond[i] | (errLatch[i] & ~clrBit);
      // One latch per error code
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          errLatch[i] <= 1'b0;
        end else begin
          errLatch[i] <= bitNext; // [RL1] [RL10]
        end
      end
    end
  endgenerate

endmodule : fault_latch

// ===== pos_substitute.sv
/*
 Position output with error value substitution.
 Assumes a valid position whenever no fault is live.
*/
`timescale 1ns/1ps
module pos_substitute (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Selection
  input  wire logic        noMeas,
  input  wire logic [1:0]  valMode,
  // Positions
  input  wire logic [23:0] posIn,
  output logic      [23:0] posOut
);

  logic [23:0] lastValid_reg; // Last good position

  // Substitute chosen by mode
  wire [23:0] substVal =
    (valMode == fault_status_pkg::VAL_ONES) ? 24'hFF_FFFF :
    (valMode == fault_status_pkg::VAL_LAST) ? lastValid_reg :
    24'h00_0000;
  wire [23:0] posNext = noMeas ? substVal : posIn; // [RL8]

  // Hold last good value and register output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastValid_reg <= 24'h00_0000;
      posOut        <= 24'h00_0000;
    end else begin
      if (!noMeas) begin
        lastValid_reg <= posIn;
      end
      posOut <= posNext;
    end
  end

endmodule : pos_substitute

// ===== fault_status_byte.sv
/*
 Fault and warning status byte of a laser distance
 meter, with register bus and interrupt.
 Assumes synchronous inputs on ref_clk and an
 Avalon-MM master that honours waitrequest.
*/
// Function
// [RL1] Manual mode keeps errors until acknowledged
// [RL2] Low received intensity sets bit 0
// [RL3] Temperature outside band sets bit 1
// [RL4] Laser off sets bit 3, informational
// [RL5] Intensity below warning sets bit 4
// [RL6] Speed above limit sets bit 5
// [RL7] Unsure plausibility sets bit 6
// [RL8] Hardware fault sets bit 2, substitutes position
// [RL9] No condition gives all-zero byte
// [RL10] Acknowledge or auto clear removes errors
// [RL11] Byte on bus only when reporting enabled
// [RL12] Warnings follow conditions, byte updates each cycle
`timescale 1ns/1ps
`include "fault_status_params.svh"
module fault_status_byte (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Measurement conditions
  input  wire logic [6:0]  intensityPct,
  input  wire logic        beamLost,
  input  wire logic [7:0]  temperature,
  input  wire logic        hwFault,
  input  wire logic [15:0] speedIn,
  input  wire logic        plausLost,
  input  wire logic [23:0] positionIn,
  // Cyclic output data bits and switching input
  input  wire logic        laserOffCmd,
  input  wire logic        ackBit,
  input  wire logic        switchIn,
  // Cyclic input data and switching output
  output logic      [7:0]  cyclicHigh,
  output logic      [23:0] positionOut,
  output logic             errorOut,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Interrupt
  output logic             irq
);

  // Software state
  logic [8:0]  ctrl_reg;     // Mode settings
  logic [15:0] speedLim_reg; // Zero turns speed check off
  logic [7:0]  irqStat_reg;  // Sticky event bits
  logic [7:0]  irqMask_reg;  // Event enables
  // Block state
  logic [2:0]  warn_reg;     // Live warnings 4..6
  logic        laserOff_reg; // Laser off flag
  logic [7:0]  statusPrev_reg;
  logic        ackPrev_reg;
  logic        switchPrev_reg;
  logic [2:0]  errLatch;     // Latched error codes
  fault_status_pkg::bus_state_e busState;

  // Control fields
  wire       autoAck  = ctrl_reg[`CTRL_AUTO_ACK];
  wire       reportEn = ctrl_reg[`CTRL_REPORT_EN];
  wire [1:0] extFunc  = ctrl_reg[`CTRL_EXT_HI:`CTRL_EXT_LO];
  wire [1:0] valMode  = ctrl_reg[`CTRL_VAL_HI:`CTRL_VAL_LO];
  wire [2:0] outFunc  = ctrl_reg[`CTRL_OUT_HI:`CTRL_OUT_LO];

  // Below 8% bit 0 is set, and bit 4 too unless the beam is lost; the warning
  // is only a notice and never stops the measurement
  // Intensity checks; beam loss counts as error
  wire intensErr  = beamLost |
                    (intensityPct < `INTENS_MIN_PCT); // [RL2]
  wire warnIntens = ~beamLost &
                    (intensityPct < `INTENS_WARN_PCT); // [RL5]
  // Both sides of the band count, low side too
  wire tempBad = ($signed(temperature) < `TEMP_LOW_C) |
                 ($signed(temperature) > `TEMP_HIGH_C); // [RL3]
  // Limit comes from the service tool path only
  wire speedOver = (speedLim_reg != 16'h0000) &
                   (speedIn > speedLim_reg); // [RL6]
  wire laserOff = laserOffCmd |
    (switchIn & (extFunc == fault_status_pkg::EXT_LASER)); // [RL4]

  // Laser off stays out of errCond: it is information,
  // so neither the latch nor the error output sees it
  // Error causes in bit order 0..2
  wire [2:0] errCond   = {hwFault, tempBad, intensErr};
  wire [2:0] warnCond  = {plausLost, speedOver, warnIntens}; // [RL7]
  wire       anyCond   = (|errCond) | (|warnCond) | laserOff;

  // Only a rising edge acknowledges, so a bit left high
  // by the master cannot keep errors cleared for ever
  // Rising edges of bus bit and switching input
  wire busAck = ackBit & ~ackPrev_reg;
  wire extAck = switchIn & ~switchPrev_reg &
                (extFunc == fault_status_pkg::EXT_ACK);
  wire ackPulse = busAck | extAck; // [RL10]

  // Assembled byte, bit 7 unused
  wire [7:0] statusByte = {1'b0, warn_reg, laserOff_reg,
                           errLatch}; // [RL9]

  // Latched error bits
  fault_latch u_latch (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .autoAck  (autoAck),
    .ackPulse (ackPulse),
    .errCond  (errCond),
    .errLatch (errLatch)
  );

  // Position with error value; no measurement on these
  pos_substitute u_pos (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .noMeas  (hwFault | intensErr),
    .valMode (valMode),
    .posIn   (positionIn),
    .posOut  (positionOut)
  );

  // Code 4 takes the latched errors only; laser off never
  // drives the switching output, warnings only by codes 5 and 6
  // Switching output selection
  wire errOutNext =
    (outFunc == 3'h1) ? statusByte[`BIT_TEMP] :
    (outFunc == 3'h2) ? statusByte[`BIT_INTENS] :
    (outFunc == 3'h3) ? statusByte[`BIT_HW] :
    (outFunc == 3'h4) ? (|errLatch) :
    (outFunc == 3'h5) ? statusByte[`BIT_WARN_SPD] :
    (outFunc == 3'h6) ? statusByte[`BIT_WARN_PLS] :
    1'b0;

  // Live bits and cyclic byte, refreshed every cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      warn_reg     <= 3'h0;
      laserOff_reg <= 1'b0;
      cyclicHigh   <= 8'h00;
      errorOut     <= 1'b0;
    end else begin
      warn_reg     <= warnCond; // [RL12]
      laserOff_reg <= laserOff; // [RL4]
      cyclicHigh   <= reportEn ? statusByte : 8'h00; // [RL11]
      errorOut     <= errOutNext;
    end
  end

  // Edge history for acknowledge and events
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ackPrev_reg    <= 1'b0;
      switchPrev_reg <= 1'b0;
      statusPrev_reg <= 8'h00;
    end else begin
      ackPrev_reg    <= ackBit;
      switchPrev_reg <= switchIn;
      statusPrev_reg <= statusByte;
    end
  end

  // Address compared in full; aliases would hide
  // software that writes to the wrong offset
  // Bus decode: answer in second cycle of a request
  wire reqOn   = read | write;
  wire doWrite = write & ~waitrequest;
  wire selCtrl = (address == `OFS_CTRL);
  wire selSpd  = (address == `OFS_SPEED_LIM);
  wire selStat = (address == `OFS_STATUS);
  wire selIrqS = (address == `OFS_IRQ_STAT);
  wire selIrqM = (address == `OFS_IRQ_MASK);
  // Unmapped reads give zero
  wire [31:0] readMux =
    selCtrl ? {23'h00_0000, ctrl_reg} :
    selSpd  ? {16'h0000, speedLim_reg} :
    selStat ? {24'h00_0000, statusByte} :
    selIrqS ? {24'h00_0000, irqStat_reg} :
    selIrqM ? {24'h00_0000, irqMask_reg} :
    32'h0000_0000;

  // Fixed answer time keeps the master simple; the cost
  // is one idle cycle between back-to-back requests
  // Handshake: one wait cycle, then a done cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busState    <= fault_status_pkg::BUS_WAIT;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      case (busState)
        fault_status_pkg::BUS_WAIT: begin
          if (reqOn) begin
            busState    <= fault_status_pkg::BUS_DONE;
            waitrequest <= 1'b0;
            readdata    <= readMux;
          end
        end
        fault_status_pkg::BUS_DONE: begin
          // Master releases after this edge
          busState    <= fault_status_pkg::BUS_WAIT;
          waitrequest <= 1'b1;
        end
        default: begin
          busState    <= fault_status_pkg::BUS_WAIT;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Unmapped offsets fall through every select and
  // are dropped without any error answer
  // Software writes take effect on the done edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= `CTRL_RESET;
      speedLim_reg <= `SPEED_RESET;
      irqMask_reg  <= `MASK_RESET;
    end else if (doWrite) begin
      if (selCtrl) begin
        ctrl_reg <= writedata[8:0];
      end
      if (selSpd) begin
        speedLim_reg <= writedata[15:0];
      end
      if (selIrqM) begin
        irqMask_reg <= writedata[7:0];
      end
    end
  end

  // Events are edges of the assembled byte, so a bit that
  // stays latched raises one event, not one per cycle
  // Events: any status bit rising
  wire [7:0] events = statusByte & ~statusPrev_reg;
  wire [7:0] w1c = (doWrite & selIrqS) ? writedata[7:0] : 8'h00;
  // A new event outranks a clear in the same cycle
  wire [7:0] irqStatNext = events | (irqStat_reg & ~w1c);

  // irq is taken from the next status, so it rises on
  // the same edge as the sticky bit that causes it
  // Sticky status and level interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_reg <= 8'h00;
      irq         <= 1'b0;
    end else begin
      irqStat_reg <= irqStatNext;
      irq         <= |(irqStatNext & irqMask_reg);
    end
  end

  // Attempts that start on the edge releasing reset still
  // see reset values one edge later, so inputs must be
  // quiet across every release of reset
  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  manual_hold_a: assert property ( // [RL1]
    (!autoAck && !ackPulse) |=>
      ((errLatch & $past(errLatch)) == $past(errLatch)))
    else $error("error code released without ack");

  intens_err_a: assert property ( // [RL2]
    intensErr |=> statusByte[`BIT_INTENS])
    else $error("intensity error bit not set");

  temp_err_a: assert property ( // [RL3]
    tempBad |=> statusByte[`BIT_TEMP])
    else $error("temperature bit not set");

  laser_off_a: assert property ( // [RL4]
    laserOff |=> statusByte[`BIT_LASER_OFF])
    else $error("laser off bit not set");

  laser_info_a: assert property ( // [RL4]
    (outFunc == 3'h4 && errLatch == 3'h0) |=> !errorOut)
    else $error("error output without an error");

  intens_warn_a: assert property ( // [RL5]
    (warnIntens && !intensErr && !hwFault) |=> statusByte[`BIT_WARN_INT]
      && positionOut == $past(positionIn))
    else $error("intensity warning wrong");

  speed_warn_a: assert property ( // [RL6]
    (speedLim_reg == 16'h0000) |=> !statusByte[`BIT_WARN_SPD])
    else $error("speed warning with check off");

  speed_over_a: assert property ( // [RL6]
    speedOver |=> statusByte[`BIT_WARN_SPD])
    else $error("speed warning not set");

  plaus_warn_a: assert property ( // [RL7]
    plausLost |=> statusByte[`BIT_WARN_PLS])
    else $error("plausibility bit not set");

  hw_subst_a: assert property ( // [RL8]
    (hwFault && valMode == fault_status_pkg::VAL_ZERO)
      |=> statusByte[`BIT_HW] && positionOut == 24'h00_0000)
    else $error("hardware fault not reported");

  hw_ones_a: assert property ( // [RL8]
    (hwFault && valMode == fault_status_pkg::VAL_ONES)
      |=> statusByte[`BIT_HW] && positionOut == 24'hFF_FFFF)
    else $error("all-ones substitute missing");

  zero_byte_a: assert property ( // [RL9]
    (!anyCond && errLatch == 3'h0) |=> statusByte == 8'h00)
    else $error("status byte not zero");

  auto_clear_a: assert property ( // [RL10]
    (autoAck && errCond == 3'h0) |=> errLatch == 3'h0)
    else $error("auto clear failed");

  ack_clear_a: assert property ( // [RL10]
    (!autoAck && ackPulse && errCond == 3'h0)
      |=> errLatch == 3'h0)
    else $error("acknowledge did not clear");

  report_gate_a: assert property ( // [RL11]
    ##1 1'b1 |-> cyclicHigh ==
      ($past(reportEn) ? $past(statusByte) : 8'h00))
    else $error("cyclic byte gating wrong");

  warn_follow_a: assert property ( // [RL12]
    1'b1 |=> statusByte[6:4] == $past(warnCond))
    else $error("warning bits do not follow");

  // A clear in the same cycle must not swallow an event
  set_wins_a: assert property (
    (events != 8'h00) |=> (irqStat_reg & $past(events)) == $past(events))
    else $error("event lost to a clear");

  // The answer stands for exactly one cycle
  wait_pulse_a: assert property (
    !waitrequest |=> waitrequest)
    else $error("wait low for more than one cycle");

endmodule : fault_status_byte

// ===== fieldbus_master.sv
/*
 Fieldbus master model: reads the cyclic high byte, drives output data bits.
 Assumes the device's ref_clk and resetn.
*/
`timescale 1ns/1ps
module fieldbus_master (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Requests from the bench
  input  wire logic       ackReq,
  input  wire logic       laserReq,
  // Cyclic data
  input  wire logic [7:0] cyclicHigh,
  output logic            ackBit,
  output logic            laserOffCmd,
  output logic      [7:0] statusSeen
);
  // Ack is one cycle wide and low between pulses, so each one is an edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ackBit      <= 1'b0;
      laserOffCmd <= 1'b0;
      statusSeen  <= 8'h00;
    end else begin
      ackBit      <= ackReq & ~ackBit;
      laserOffCmd <= laserReq;
      statusSeen  <= cyclicHigh;
    end
  end
endmodule : fieldbus_master

// ===== tb_fault_status_byte.sv
/*
 Self-checking bench of the fault status byte.
 Assumes fieldbus_master as the far side and an Avalon-MM bus.
*/
`timescale 1ns/1ps
`include "fault_status_params.svh"
module tb_fault_status_byte;
  logic        ref_clk, resetn, beamLost, hwFault, plausLost, switchIn;
  logic        ackBit, laserOffCmd, ackReq, laserReq, read, write, waitrequest, irq, errorOut;
  logic [6:0]  intensityPct;
  logic [7:0]  temperature, cyclicHigh, statusSeen;
  logic [15:0] speedIn;
  logic [23:0] positionIn, positionOut;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, q;
  int          seed, miscompares, nChecks;
  logic [6:0]  pv;
  logic [7:0]  tv;
  logic [15:0] sv;
  logic        bl, hw, pl, lr, sw;
  logic [23:0] pp, lp;
  logic [7:0]  ev;
  logic [2:0]  of;
  logic [1:0]  vm;
  // Offsets with an unmapped hole at the end
  logic [5:0]  offs [6] = '{`OFS_CTRL, `OFS_SPEED_LIM, `OFS_STATUS, `OFS_IRQ_STAT, `OFS_IRQ_MASK, 6'h14};
  logic [6:0]  cor [6] = '{7'h07, 7'h08, 7'h0B, 7'h0C, 7'h00, 7'h64};

  fault_status_byte DUT (.ref_clk(ref_clk), .resetn(resetn), .intensityPct(intensityPct), .beamLost(beamLost),
    .temperature(temperature), .hwFault(hwFault), .speedIn(speedIn), .plausLost(plausLost),
    .positionIn(positionIn), .laserOffCmd(laserOffCmd), .ackBit(ackBit), .switchIn(switchIn),
    .cyclicHigh(cyclicHigh), .positionOut(positionOut), .errorOut(errorOut), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));
  fieldbus_master master (.ref_clk(ref_clk), .resetn(resetn), .ackReq(ackReq), .laserReq(laserReq),
    .cyclicHigh(cyclicHigh), .ackBit(ackBit), .laserOffCmd(laserOffCmd), .statusSeen(statusSeen));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Expected status byte from live conditions, auto clear mode
  function automatic logic [7:0] exp_status(input logic [6:0] p, input logic b, input logic [7:0] t,
                                            input logic h, input logic [15:0] s, input logic l, input logic o);
    logic [7:0] e;
    e = 8'h00;
    e[`BIT_INTENS]    = b | (p < `INTENS_MIN_PCT);
    e[`BIT_TEMP]      = ($signed(t) < `TEMP_LOW_C) | ($signed(t) > `TEMP_HIGH_C);
    e[`BIT_HW]        = h;
    e[`BIT_LASER_OFF] = o;
    e[`BIT_WARN_INT]  = ~b & (p < `INTENS_WARN_PCT);
    e[`BIT_WARN_SPD]  = s > 16'h03E8;
    e[`BIT_WARN_PLS]  = l;
    return e;
  endfunction : exp_status

  // Expected switching output per output function, auto clear mode
  function automatic logic exp_errout(input logic [2:0] f, input logic [7:0] e);
    case (f)
      3'h1: return e[`BIT_TEMP];
      3'h2: return e[`BIT_INTENS];
      3'h3: return e[`BIT_HW];
      3'h4: return |e[2:0];
      3'h5: return e[`BIT_WARN_SPD];
      3'h6: return e[`BIT_WARN_PLS];
      default: return 1'b0;
    endcase
  endfunction : exp_errout

  // Expected substitute position per error value mode
  function automatic logic [23:0] exp_subst(input logic [1:0] m, input logic [23:0] last);
    case (m)
      2'h1: return 24'hFF_FFFF;
      2'h2: return last;
      default: return 24'h00_0000;
    endcase
  endfunction : exp_subst

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) miscompares++;
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rdchk

  // Status path needs up to four edges, the other two are margin
  task automatic settle;
    repeat (6) @(posedge ref_clk);
  endtask : settle

  // Ack pulse from the master or from the switching input
  task automatic ack(input logic viaSwitch);
    if (viaSwitch) switchIn <= 1'b1;
    else ackReq <= 1'b1;
    @(posedge ref_clk);
    switchIn <= 1'b0;
    ackReq   <= 1'b0;
    @(posedge ref_clk);
  endtask : ack

  task automatic complete_run;
    if (miscompares == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run;
  end

  // Main sequence
  initial begin
    seed = 52;
    miscompares = 0;
    nChecks = 0;
    resetn = 1'b0;
    {beamLost, hwFault, plausLost, switchIn, ackReq, laserReq, read, write} = '0;
    intensityPct = 7'h64;
    temperature = 8'h14;
    speedIn = 16'h0000;
    address = 6'h00;
    writedata = 32'h0000_0000;
    positionIn = 24'h12_3456;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    foreach (offs[i]) rdchk(offs[i], 32'h0000_0000);
    // Reporting off hides the byte
    hwFault <= 1'b1;
    settle;
    chk(statusSeen, 8'h00);
    rdchk(`OFS_STATUS, 32'h0000_0004);
    // Manual ack, switch as ack, all-ones substitute
    wr(`OFS_CTRL, 32'h0000_001E);
    settle;
    chk(statusSeen, 8'h04);
    chk(positionOut, 24'hFF_FFFF);
    ack(1'b0);
    settle;
    chk(statusSeen, 8'h04);
    hwFault <= 1'b0;
    settle;
    chk(statusSeen, 8'h04);
    chk(positionOut, positionIn);
    ack(1'b1);
    settle;
    chk(statusSeen, 8'h00);
    // Interrupt raised, held past ack, cleared by write one
    wr(`OFS_IRQ_STAT, 32'h0000_00FF);
    wr(`OFS_IRQ_MASK, 32'h0000_0004);
    hwFault <= 1'b1;
    settle;
    chk(irq, 1'b1);
    hwFault <= 1'b0;
    ack(1'b0);
    settle;
    chk(statusSeen, 8'h00);
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STAT, 32'h0000_0004);
    settle;
    chk(irq, 1'b0);
    rdchk(`OFS_IRQ_STAT, 32'h0000_0000);
    // Auto clear, switch as laser off, random conditions
    wr(`OFS_SPEED_LIM, 32'h0000_03E8);
    rdchk(`OFS_SPEED_LIM, 32'h0000_03E8);
    lp = 24'h12_3456;
    for (int i = 0; i < 60; i++) begin
      of = 3'(i % 8);
      vm = 2'(i % 3);
      // Auto ack, reporting on, switch as laser off; modes rotate
      wr(`OFS_CTRL, {23'h00_0000, of, vm, 4'hB});
      pv = (i < 6) ? cor[i] : 7'($unsigned($random(seed)) % 101);
      tv = 8'(($unsigned($random(seed)) % 66) - 5);
      sv = 16'($unsigned($random(seed)) % 2000);
      {bl, hw, pl, lr, sw} = 5'($random(seed));
      bl = bl & hw & (i > 5);
      pp = 24'($random(seed));
      ev = exp_status(pv, bl, tv, hw & ~pl, sv, pl, lr | sw);
      if (!(ev[`BIT_INTENS] | ev[`BIT_HW])) lp = pp;
      intensityPct <= pv;
      temperature  <= tv;
      speedIn      <= sv;
      beamLost     <= bl;
      hwFault      <= hw & ~pl;
      plausLost    <= pl;
      laserReq     <= lr;
      switchIn     <= sw;
      positionIn   <= pp;
      settle;
      chk(statusSeen, ev);
      chk(errorOut, exp_errout(of, ev));
      chk(positionOut, (ev[`BIT_INTENS] | ev[`BIT_HW]) ? exp_subst(vm, lp) : pp);
    end
    // Mid-run reset with quiet inputs: outputs idle, registers cleared
    {beamLost, hwFault, plausLost, switchIn, laserReq} <= '0;
    intensityPct <= 7'h64;
    temperature  <= 8'h14;
    resetn       <= 1'b0;
    @(posedge ref_clk);
    chk({irq, errorOut, waitrequest, cyclicHigh}, 11'h100);
    chk(positionOut, 24'h00_0000);
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rdchk(`OFS_CTRL, 32'h0000_0000);
    rdchk(`OFS_IRQ_STAT, 32'h0000_0000);
    complete_run;
  end
endmodule : tb_fault_status_byte
